// ==== pkg/pcg_pkg.sv ====
// Constants and types for the port clock gate and soft reset block
package pcg_pkg;
  localparam int unsigned DW = 32;
  localparam int unsigned AW = 12;
  localparam int unsigned NPORT = 8;
  // Register byte offsets
  localparam logic [AW-1:0] OFF_SOFT_RST0 = 12'h040;
  localparam logic [AW-1:0] OFF_DS_GATE = 12'h128;
  localparam logic [AW-1:0] OFF_INT_STAT = 12'h150;
  localparam logic [AW-1:0] OFF_INT_MASK = 12'h154;
  // Reset values
  localparam logic [DW-1:0] RST_SOFT_RST0 = 32'h0000_0000;
  localparam logic [NPORT-1:0] RST_DS_GATE = 8'h00;
  localparam logic [1:0] RST_INT = 2'h0;
  // Soft reset field positions
  localparam int unsigned BIT_ADC_RST = 16;
  localparam int unsigned BIT_HIBERNATION_RESET = 6;
  localparam int unsigned BIT_WATCHDOG_RESET = 3;
  localparam logic [DW-1:0] SOFT_RST0_IMPL = 32'h0001_0048;
  // Interrupt status fields
  localparam int unsigned IRQ_GATED_ACCESS = 0;
  localparam int unsigned IRQ_RST_BLOCKED = 1;
  localparam int unsigned NIRQ = 2;
  // Power modes
  typedef enum logic [2:0] {
    MODE_RUN   = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_DEEP  = 3'b100
  } pcg_mode_t;
endpackage

// ==== pkg/pcg_reg_if.sv ====
// Register access carrier between the bus slave and the register file
`timescale 1ns/1ps
`default_nettype none
interface pcg_reg_if;
  logic                   wr;
  logic [pcg_pkg::AW-1:0] addr;
  logic [pcg_pkg::DW-1:0] wdata;
  logic [pcg_pkg::DW-1:0] rdata;
  logic                   hit;
  modport slv (output wr, output addr, output wdata, input rdata, input hit);
  modport regs (input wr, input addr, input wdata, output rdata, output hit);
endinterface
`default_nettype wire

// ==== hdl/pcg_apb_slave.sv ====
// APB slave front end with zero wait states
`timescale 1ns/1ps
`default_nettype none
module pcg_apb_slave (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [pcg_pkg::AW-1:0] paddr_i,
  input  wire logic [pcg_pkg::DW-1:0] pwdata_i,
  output logic      [pcg_pkg::DW-1:0] prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  pcg_reg_if.slv                      rif
);
  logic [pcg_pkg::DW-1:0] prdata_q;

  assign rif.addr  = paddr_i;
  assign rif.wdata = pwdata_i;
  assign rif.wr    = psel_i & penable_i & pwrite_i & rif.hit;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~rif.hit;
  assign prdata_o  = prdata_q;

  // Read data captured in the setup cycle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prdata_q <= '0;
    else if (psel_i && !penable_i)
      prdata_q <= pwrite_i ? '0 : rif.rdata;
  end
endmodule
`default_nettype wire

// ==== hdl/pcg_gate_sel.sv ====
// Chooses the active port clock gate set from the power mode
`timescale 1ns/1ps
`default_nettype none
module pcg_gate_sel #(
  parameter int unsigned N = 8
) (
  input  wire logic              auto_i,
  input  wire pcg_pkg::pcg_mode_t mode_i,
  input  wire logic [N-1:0]      run_i,
  input  wire logic [N-1:0]      sleep_i,
  input  wire logic [N-1:0]      deep_i,
  output logic      [N-1:0]      en_o
);
  always_comb
  begin
    en_o = run_i;
    if (auto_i)
    begin
      unique case (mode_i)
        pcg_pkg::MODE_RUN:   en_o = run_i;
        pcg_pkg::MODE_SLEEP: en_o = sleep_i;
        pcg_pkg::MODE_DEEP:  en_o = deep_i;
        default:             en_o = run_i;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== hdl/pcg_top.sv ====
// Port clock gating for deep sleep and peripheral soft reset controls
`timescale 1ns/1ps
`default_nettype none
module pcg_top #(
  parameter int unsigned NPORT = pcg_pkg::NPORT
) (
  input  wire logic                   CLK_I,
  input  wire logic                   RST_N_I,
  input  wire logic                   PSEL_I,
  input  wire logic                   PENABLE_I,
  input  wire logic                   PWRITE_I,
  input  wire logic [pcg_pkg::AW-1:0] PADDR_I,
  input  wire logic [pcg_pkg::DW-1:0] PWDATA_I,
  output logic      [pcg_pkg::DW-1:0] PRDATA_O,
  output logic                        PREADY_O,
  output logic                        PSLVERR_O,
  input  wire logic [NPORT-1:0]       RUN_GATE_I,
  input  wire logic [NPORT-1:0]       SLEEP_GATE_I,
  input  wire logic                   AUTO_GATING_I,
  input  wire logic                   SLEEP_I,
  input  wire logic                   DEEP_SLEEP_I,
  input  wire logic [pcg_pkg::DW-1:0] CAP_MASK_I,
  input  wire logic [NPORT-1:0]       PORT_ACCESS_I,
  output logic                        BUS_FAULT_O,
  output logic      [NPORT-1:0]       PORT_CLK_EN_O,
  output logic                        ADC_RST_O,
  output logic                        HIBERNATION_RESET_O,
  output logic                        WATCHDOG_RESET_O,
  output logic                        IRQ_O
);
  pcg_reg_if rif ();

  logic [pcg_pkg::DW-1:0] soft_rst_q;
  logic [NPORT-1:0]       ds_gate_q;
  logic [NPORT-1:0]       port_en_q;
  logic [NPORT-1:0]       port_en_d;
  logic [pcg_pkg::NIRQ-1:0] int_stat_q;
  logic [pcg_pkg::NIRQ-1:0] int_mask_q;
  logic [pcg_pkg::NIRQ-1:0] evt;
  pcg_pkg::pcg_mode_t     mode_q;
  pcg_pkg::pcg_mode_t     mode_d;
  logic                   wr_rst;
  logic                   wr_ds;
  logic                   wr_stat;
  logic                   wr_mask;
  logic [pcg_pkg::DW-1:0] rst_wmask;

  function automatic logic [pcg_pkg::DW-1:0] zext_port(input logic [NPORT-1:0] v);
    logic [pcg_pkg::DW-1:0] r;
    r = '0;
    r[NPORT-1:0] = v;
    return r;
  endfunction

  function automatic logic [pcg_pkg::DW-1:0] zext_irq(input logic [pcg_pkg::NIRQ-1:0] v);
    logic [pcg_pkg::DW-1:0] r;
    r = '0;
    r[pcg_pkg::NIRQ-1:0] = v;
    return r;
  endfunction

  pcg_apb_slave u_apb (
    .clk_i     (CLK_I),
    .rst_n_i   (RST_N_I),
    .psel_i    (PSEL_I),
    .penable_i (PENABLE_I),
    .pwrite_i  (PWRITE_I),
    .paddr_i   (PADDR_I),
    .pwdata_i  (PWDATA_I),
    .prdata_o  (PRDATA_O),
    .pready_o  (PREADY_O),
    .pslverr_o (PSLVERR_O),
    .rif       (rif.slv)
  );

  // Address decode
  assign wr_rst  = rif.wr && rif.addr == pcg_pkg::OFF_SOFT_RST0;
  assign wr_ds   = rif.wr && rif.addr == pcg_pkg::OFF_DS_GATE;
  assign wr_stat = rif.wr && rif.addr == pcg_pkg::OFF_INT_STAT;
  assign wr_mask = rif.wr && rif.addr == pcg_pkg::OFF_INT_MASK;

  always_comb
  begin
    rif.hit   = 1'b1;
    rif.rdata = '0;
    unique case (rif.addr)
      pcg_pkg::OFF_SOFT_RST0: rif.rdata = soft_rst_q;
      pcg_pkg::OFF_DS_GATE:   rif.rdata = zext_port(ds_gate_q);
      pcg_pkg::OFF_INT_STAT:  rif.rdata = zext_irq(int_stat_q);
      pcg_pkg::OFF_INT_MASK:  rif.rdata = zext_irq(int_mask_q);
      default:                rif.hit = 1'b0;
    endcase
  end

  // Deep-sleep gate register, one bit per port
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      ds_gate_q <= pcg_pkg::RST_DS_GATE;
    else if (wr_ds)
      ds_gate_q <= rif.wdata[NPORT-1:0];
  end

  // Soft reset register, writes masked by capability
  assign rst_wmask = CAP_MASK_I & pcg_pkg::SOFT_RST0_IMPL;

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      soft_rst_q <= pcg_pkg::RST_SOFT_RST0;
    else if (wr_rst)
      soft_rst_q <= (rif.wdata & rst_wmask) | (soft_rst_q & ~rst_wmask);
  end

  // Reset controls to units
  assign ADC_RST_O = soft_rst_q[pcg_pkg::BIT_ADC_RST];
  assign HIBERNATION_RESET_O = soft_rst_q[pcg_pkg::BIT_HIBERNATION_RESET];
  assign WATCHDOG_RESET_O = soft_rst_q[pcg_pkg::BIT_WATCHDOG_RESET];

  // Power mode tracking, deep sleep has priority
  always_comb
  begin
    mode_d = pcg_pkg::MODE_RUN;
    if (DEEP_SLEEP_I)
      mode_d = pcg_pkg::MODE_DEEP;
    else if (SLEEP_I)
      mode_d = pcg_pkg::MODE_SLEEP;
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      mode_q <= pcg_pkg::MODE_RUN;
    else
      mode_q <= mode_d;
  end

  pcg_gate_sel #(
    .N (NPORT)
  ) u_sel (
    .auto_i  (AUTO_GATING_I),
    .mode_i  (mode_q),
    .run_i   (RUN_GATE_I),
    .sleep_i (SLEEP_GATE_I),
    .deep_i  (ds_gate_q),
    .en_o    (port_en_d)
  );

  // Registered port clock enables
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      port_en_q <= '0;
    else
      port_en_q <= port_en_d;
  end

  assign PORT_CLK_EN_O = port_en_q;
  assign BUS_FAULT_O = |(PORT_ACCESS_I & ~port_en_q);

  // Interrupt events
  assign evt[pcg_pkg::IRQ_GATED_ACCESS] = BUS_FAULT_O;
  assign evt[pcg_pkg::IRQ_RST_BLOCKED] =
    wr_rst && |(rif.wdata & pcg_pkg::SOFT_RST0_IMPL & ~CAP_MASK_I);

  // Sticky status, write one to clear, set wins
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      int_stat_q <= pcg_pkg::RST_INT;
    else if (wr_stat)
      int_stat_q <= (int_stat_q & ~rif.wdata[pcg_pkg::NIRQ-1:0]) | evt;
    else
      int_stat_q <= int_stat_q | evt;
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      int_mask_q <= pcg_pkg::RST_INT;
    else if (wr_mask)
      int_mask_q <= rif.wdata[pcg_pkg::NIRQ-1:0];
  end

  assign IRQ_O = |(int_stat_q & int_mask_q);

  // Checks
  logic apb_wr;
  assign apb_wr = PSEL_I & PENABLE_I & PWRITE_I;

  sequence s_ds_write;
    apb_wr && PADDR_I == pcg_pkg::OFF_DS_GATE;
  endsequence

  sequence s_rst_write;
    apb_wr && PADDR_I == pcg_pkg::OFF_SOFT_RST0;
  endsequence

  property p_ds_store;
    @(posedge CLK_I) disable iff (!RST_N_I)
    s_ds_write |=> ds_gate_q == $past(PWDATA_I[NPORT-1:0]);
  endproperty
  a_ds_store: assert property (p_ds_store) else $error("Deep gate write lost");

  property p_fault;
    @(posedge CLK_I) disable iff (!RST_N_I)
    (PORT_ACCESS_I & ~PORT_CLK_EN_O) != '0
      |-> BUS_FAULT_O ##1 int_stat_q[pcg_pkg::IRQ_GATED_ACCESS];
  endproperty
  a_fault: assert property (p_fault) else $error("Gated access fault wrong");

  property p_fault_quiet;
    @(posedge CLK_I) disable iff (!RST_N_I)
    PORT_ACCESS_I == '0 |-> !BUS_FAULT_O;
  endproperty
  a_fault_quiet: assert property (p_fault_quiet) else $error("Fault without access");

  property p_reset_zero;
    @(posedge CLK_I)
    $rose(RST_N_I) |-> ds_gate_q == '0 && soft_rst_q == '0 && PORT_CLK_EN_O == '0;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("Reset state not zero");

  property p_deep_sel;
    @(posedge CLK_I) disable iff (!RST_N_I)
    (AUTO_GATING_I && DEEP_SLEEP_I) ##1 AUTO_GATING_I |=> PORT_CLK_EN_O == $past(ds_gate_q);
  endproperty
  a_deep_sel: assert property (p_deep_sel) else $error("Deep sleep set not used");

  property p_run_sel;
    @(posedge CLK_I) disable iff (!RST_N_I)
    !AUTO_GATING_I |=> PORT_CLK_EN_O == $past(RUN_GATE_I);
  endproperty
  a_run_sel: assert property (p_run_sel) else $error("Run set not used");

  property p_ds_upper;
    @(posedge CLK_I) disable iff (!RST_N_I)
    PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == pcg_pkg::OFF_DS_GATE
      |-> PRDATA_O[pcg_pkg::DW-1:NPORT] == '0;
  endproperty
  a_ds_upper: assert property (p_ds_upper) else $error("Deep gate upper bits set");

  property p_rst_mask;
    @(posedge CLK_I) disable iff (!RST_N_I)
    s_rst_write |=> (soft_rst_q & ~$past(rst_wmask)) == ($past(soft_rst_q) & ~$past(rst_wmask));
  endproperty
  a_rst_mask: assert property (p_rst_mask) else $error("Masked reset bit changed");

  property p_unit_rst;
    @(posedge CLK_I) disable iff (!RST_N_I)
    s_rst_write ##1 1'b1 |-> ADC_RST_O == $past(PWDATA_I[pcg_pkg::BIT_ADC_RST])
                          || !$past(rst_wmask[pcg_pkg::BIT_ADC_RST]);
  endproperty
  a_unit_rst: assert property (p_unit_rst) else $error("Converter reset not applied");

  property p_rst_blocked;
    @(posedge CLK_I) disable iff (!RST_N_I)
    s_rst_write ##0 (PWDATA_I & pcg_pkg::SOFT_RST0_IMPL & ~CAP_MASK_I) != '0
      |=> int_stat_q[pcg_pkg::IRQ_RST_BLOCKED];
  endproperty
  a_rst_blocked: assert property (p_rst_blocked) else $error("Blocked write not flagged");

  property p_rst_hold;
    @(posedge CLK_I) disable iff (!RST_N_I)
    !(apb_wr && PADDR_I == pcg_pkg::OFF_SOFT_RST0)
      |=> $stable({ADC_RST_O, HIBERNATION_RESET_O, WATCHDOG_RESET_O});
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("Unit reset changed unwritten");

  property p_rst_reserved;
    @(posedge CLK_I) disable iff (!RST_N_I)
    (soft_rst_q & ~pcg_pkg::SOFT_RST0_IMPL) == '0;
  endproperty
  a_rst_reserved: assert property (p_rst_reserved) else $error("Reserved reset bit set");

  property p_hib_wdt;
    @(posedge CLK_I) disable iff (!RST_N_I)
    s_rst_write ##1 1'b1 |->
      (HIBERNATION_RESET_O == $past(PWDATA_I[pcg_pkg::BIT_HIBERNATION_RESET])
      || !$past(rst_wmask[pcg_pkg::BIT_HIBERNATION_RESET]))
      && (WATCHDOG_RESET_O == $past(PWDATA_I[pcg_pkg::BIT_WATCHDOG_RESET])
      || !$past(rst_wmask[pcg_pkg::BIT_WATCHDOG_RESET]));
  endproperty
  a_hib_wdt: assert property (p_hib_wdt) else $error("Hibernation or watchdog reset wrong");
endmodule
`default_nettype wire

// ==== tb/pcg_top_tb.sv ====
// Self-checking bench for the port clock gate and soft reset block
`timescale 1ns/1ps
`default_nettype none
module pcg_top_tb;
  localparam logic [11:0] A_RST = pcg_pkg::OFF_SOFT_RST0;
  localparam logic [11:0] A_DS  = pcg_pkg::OFF_DS_GATE;
  localparam logic [11:0] A_ST  = pcg_pkg::OFF_INT_STAT;
  localparam logic [11:0] A_MSK = pcg_pkg::OFF_INT_MASK;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  run_gate;
  logic [7:0]  sleep_gate;
  logic [7:0]  port_access;
  logic [7:0]  port_en;
  logic        auto_gate;
  logic        sleep;
  logic        deep;
  logic        fault;
  logic        rst_convert;
  logic        rst_hibernate;
  logic        rst_watchdog;
  logic        irq;
  logic [31:0] cap_mask;
  logic [31:0] rd;
  logic        err;
  int          failures;
  int          total_checks;
  int          cycles;
  logic [2:0]  mode_tab [4];
  logic [7:0]  exp_tab [4];

  pcg_top pcg_top_i (
    .CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .RUN_GATE_I(run_gate), .SLEEP_GATE_I(sleep_gate),
    .AUTO_GATING_I(auto_gate), .SLEEP_I(sleep), .DEEP_SLEEP_I(deep), .CAP_MASK_I(cap_mask),
    .PORT_ACCESS_I(port_access), .BUS_FAULT_O(fault), .PORT_CLK_EN_O(port_en),
    .ADC_RST_O(rst_convert), .HIBERNATION_RESET_O(rst_hibernate),
    .WATCHDOG_RESET_O(rst_watchdog), .IRQ_O(irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One APB transfer; waits for pready, the bench timeout bounds the wait
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      print_verdict;
    end
  end

  initial
  begin
    failures = 0;
    total_checks = 0;
    cycles = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    run_gate = 8'h3c;
    sleep_gate = 8'hc3;
    port_access = 8'h00;
    auto_gate = 1'b0;
    sleep = 1'b0;
    deep = 1'b0;
    cap_mask = 32'hffff_ffff;
    mode_tab = '{3'b001, 3'b100, 3'b011, 3'b111};
    exp_tab = '{8'h3c, 8'h3c, 8'hc3, 8'ha5};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, A_DS, 32'h0);
    check(rd, 32'h0000_0000);
    apb(1'b0, A_RST, 32'h0);
    check(rd, 32'h0000_0000);
    apb(1'b1, A_DS, 32'hffff_ffff);
    apb(1'b0, A_DS, 32'h0);
    check(rd, 32'h0000_00ff);
    apb(1'b1, A_DS, 32'h0000_00a5);
    apb(1'b0, A_DS, 32'h0);
    check(rd, 32'h0000_00a5);
    // Table of {deep, sleep, auto} against expected enables
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      {deep, sleep, auto_gate} <= mode_tab[k];
      repeat (3) @(posedge clk);
      @(negedge clk);
      check({24'h0, port_en}, {24'h0, exp_tab[k]});
    end
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      port_access <= 8'h01 << i;
      @(negedge clk);
      check({31'h0, fault}, {31'h0, ~exp_tab[3][i]});
    end
    @(posedge clk);
    port_access <= 8'h00;
    apb(1'b0, A_ST, 32'h0);
    check(rd, 32'h0000_0001);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, A_MSK, 32'h0000_0003);
    @(negedge clk);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, A_ST, 32'h0000_0001);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, A_RST, 32'hffff_ffff);
    @(negedge clk);
    check({29'h0, rst_convert, rst_hibernate, rst_watchdog}, 32'h7);
    apb(1'b0, A_RST, 32'h0);
    check(rd, 32'h0001_0048);
    apb(1'b1, A_RST, 32'h0);
    @(negedge clk);
    check({29'h0, rst_convert, rst_hibernate, rst_watchdog}, 32'h0);
    @(posedge clk);
    cap_mask <= 32'hffff_ffbf;
    apb(1'b1, A_RST, 32'h0001_0048);
    apb(1'b0, A_RST, 32'h0);
    check(rd, 32'h0001_0008);
    check({29'h0, rst_convert, rst_hibernate, rst_watchdog}, 32'h5);
    check({31'h0, irq}, 32'h1);
    apb(1'b0, A_ST, 32'h0);
    check(rd, 32'h0000_0002);
    apb(1'b1, 12'h0a0, 32'hffff_ffff);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 12'h0a0, 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    print_verdict;
  end
endmodule
`default_nettype wire
